/* pkg/adc_misc_regs.svh */
// Behaviour
// - swing enable field: 00 off, 11 on
// - all four check bits lower min rate
// - override bit picks pin or register
// - disable bit kills enhancement under override
// - every register resets to zero
// - all channels sampled on falling edge
// - result appears ten clocks after sampling; out_data shows it two clocks later, after the buffer
// - output words are twos complement
// - output words move on both out_clk edges, launched from the rising clock edge
`ifndef ADC_MISC_REGS_SVH
`define ADC_MISC_REGS_SVH

// register indices, byte address is index times four
`define IDX_LCC_A      8'h4a
`define IDX_LCC_B      8'h62
`define IDX_LCC_C      8'h92
`define IDX_LCC_D      8'h7a
`define IDX_OVERRIDE   8'hea
`define IDX_SWING      8'hf1
`define IDX_TUNING_B   8'hf5
`define IDX_PDN        8'hfe
`define IDX_ENH_DIS    8'h44

// number of register slots
`define CR_NREG        9

// writable bit masks, other bits read zero
`define MSK_LCC        8'h01
`define MSK_OVERRIDE   8'h80
`define MSK_SWING      8'h23
`define MSK_TUNING_B   8'h42
`define MSK_PDN        8'h0f
`define MSK_ENH_DIS    8'h01

// reset value of every register
`define CR_RESET       8'h00

// field positions
`define BIT_LCC        0
`define BIT_OVERRIDE   7
`define BIT_ENH_DIS    0
`define SWING_HI       1
`define SWING_LO       0
`define SWING_ON_CODE  2'h3

// pipeline depth in sampling clocks
`define CONV_LATENCY   10
// sample width and sign bit
`define SMP_W          14
`define SMP_MSB        13

`endif

/* pkg/adc_misc_pkg.sv */
package adc_misc_pkg;

    // one sample of each of the four channels
    typedef struct packed {
        logic [13:0] d;
        logic [13:0] c;
        logic [13:0] b;
        logic [13:0] a;
    } quad_sample_t;

    // decoded configuration seen by the converter
    typedef struct packed {
        logic       swing_on;
        logic       low_clock_ok;
        logic       enh_on;
        logic [3:0] pdn;
    } conv_cfg_t;

endpackage

/* core/sample_buf.sv */
`timescale 1ns/100ps
// two-entry buffer between the pipeline and the output port
module sample_buf #(
    parameter int W     = 56,
    parameter int DEPTH = 2
) (
    // clocking
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];  // entry storage
    logic [AW-1:0] wr_r;          // write index
    logic [AW-1:0] rd_r;          // read index
    logic [AW:0]   cnt_r;         // entries held
    logic          push;          // accepted write
    logic          pop;           // accepted read

    // honest full and empty
    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;

    // entry write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // never more than depth entries
    buf_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_r <= (AW+1)'(DEPTH))
        else $error("buffer count above depth");
endmodule

/* core/adc_misc_config_regs.sv */
`timescale 1ns/100ps
`include "adc_misc_regs.svh"
// configuration registers and digital output path of the converter
module adc_misc_config_regs (
    // clocking
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        ce,
    // wishbone slave
    input  wire logic                        cyc_i,
    input  wire logic                        stb_i,
    input  wire logic                        we_i,
    input  wire logic [9:0]                  adr_i,
    input  wire logic [3:0]                  sel_i,
    input  wire logic [31:0]                 dat_i,
    output logic [31:0]                      dat_o,
    output logic                             ack_o,
    // pins and converter core
    input  wire logic                        enhancement_select_pin,
    input  wire adc_misc_pkg::quad_sample_t  conv_code,
    output adc_misc_pkg::conv_cfg_t          cfg,
    // double data rate output port
    input  wire logic                        out_ready,
    output logic                             out_clk,
    output adc_misc_pkg::quad_sample_t       out_data
);
    typedef adc_misc_pkg::quad_sample_t qs_t;

    // slot index to register index
    function automatic logic [7:0] slot_idx(input int s);
        case (s)
            0: return `IDX_LCC_A;
            1: return `IDX_LCC_B;
            2: return `IDX_LCC_C;
            3: return `IDX_LCC_D;
            4: return `IDX_OVERRIDE;
            5: return `IDX_SWING;
            6: return `IDX_TUNING_B;
            7: return `IDX_PDN;
            default: return `IDX_ENH_DIS;
        endcase
    endfunction

    // slot index to writable mask
    function automatic logic [7:0] slot_msk(input int s);
        case (s)
            0, 1, 2, 3: return `MSK_LCC;
            4: return `MSK_OVERRIDE;
            5: return `MSK_SWING;
            6: return `MSK_TUNING_B;
            7: return `MSK_PDN;
            default: return `MSK_ENH_DIS;
        endcase
    endfunction

    // offset binary to twos complement, zero when powered down
    function automatic logic [13:0] to_tc(input logic [13:0] raw,
                                          input logic pd);
        logic [13:0] v;
        v = raw;
        v[`SMP_MSB] = ~raw[`SMP_MSB];
        return pd ? '0 : v;
    endfunction

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [7:0]  regs_r [`CR_NREG];  // register storage
    logic [`CR_NREG-1:0] hit;        // per slot address match
    logic        req;                // live request not yet answered
    logic        wr_en;              // write accepted this edge
    logic [7:0]  rd_byte;            // selected read value
    logic [31:0] rd_nxt;             // read data next value

    assign req   = cyc_i && stb_i && !ack_o;
    assign wr_en = ce && req && we_i && sel_i[0];

    // one register per slot, masked so reserved bits stay zero
    generate
        for (genvar s = 0; s < `CR_NREG; s++) begin : g_reg
            assign hit[s] = (adr_i[9:2] == slot_idx(s));
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_r[s] <= `CR_RESET;
                end else if (wr_en && hit[s]) begin
                    regs_r[s] <= dat_i[7:0] & slot_msk(s);
                end
            end
        end
    endgenerate

    // read mux, unmapped reads return zero
    always_comb begin
        rd_byte = 8'h00;
        for (int s = 0; s < `CR_NREG; s++) begin
            if (hit[s]) begin
                rd_byte = regs_r[s];
            end
        end
        rd_nxt = {24'h000000, rd_byte};
    end

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else if (ce) begin
            ack_o <= req;
            if (req && !we_i) begin
                dat_o <= rd_nxt;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    logic override_bit;  // register governs enhancement
    logic dis_bit;       // enhancement disable bit
    logic [1:0] swing_f; // swing control enable field

    assign override_bit = regs_r[4][`BIT_OVERRIDE];
    assign dis_bit      = regs_r[8][`BIT_ENH_DIS];
    assign swing_f      = regs_r[5][`SWING_HI:`SWING_LO];

    // swing control only on the enabled code, reserved codes off
    assign cfg.swing_on = (swing_f == `SWING_ON_CODE);
    // reduced minimum rate needs all four check bits
    assign cfg.low_clock_ok = regs_r[0][`BIT_LCC]
                           && regs_r[1][`BIT_LCC]
                           && regs_r[2][`BIT_LCC]
                           && regs_r[3][`BIT_LCC];
    // pin or register chooses the enhancement
    assign cfg.enh_on = override_bit ? !dis_bit
                                     : enhancement_select_pin;
    // channel power-down, bit 3 is channel d down to bit 0 a
    assign cfg.pdn = regs_r[7][3:0];

    // ------------------------------------------------------------
    // conversion path
    // ------------------------------------------------------------
    qs_t  cap_r;                       // falling edge capture
    qs_t  pipe_r [`CONV_LATENCY];      // latency stages
    logic [`CONV_LATENCY-1:0] fill_r;  // stage holds a sample
    logic adv;                         // pipeline moves this edge
    logic buf_in_ready;                // buffer accepts a word
    logic buf_out_valid;               // buffer holds a word
    qs_t  buf_out;                     // word at buffer head
    logic pop;                         // word leaves on the port

    assign adv = ce && buf_in_ready;

    // all channels caught together on the falling edge
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_r <= '0;
        end else if (ce) begin
            cap_r <= conv_code;
        end
    end

    // ten stages, coding and power-down applied on entry
    generate
        for (genvar k = 0; k < `CONV_LATENCY; k++) begin : g_stage
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pipe_r[k] <= '0;
                    fill_r[k] <= 1'b0;
                end else if (adv) begin
                    if (k == 0) begin
                        pipe_r[k].a <= to_tc(cap_r.a, cfg.pdn[0]);
                        pipe_r[k].b <= to_tc(cap_r.b, cfg.pdn[1]);
                        pipe_r[k].c <= to_tc(cap_r.c, cfg.pdn[2]);
                        pipe_r[k].d <= to_tc(cap_r.d, cfg.pdn[3]);
                        fill_r[k]   <= 1'b1;
                    end else begin
                        pipe_r[k] <= pipe_r[(k == 0) ? 0 : k - 1];
                        fill_r[k] <= fill_r[(k == 0) ? 0 : k - 1];
                    end
                end
            end
        end
    endgenerate

    // stall-safe hand-off to the output port
    sample_buf #(
        .W     ($bits(qs_t)),
        .DEPTH (2)
    ) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (fill_r[`CONV_LATENCY-1]),
        .in_ready  (buf_in_ready),
        .in_data   (pipe_r[`CONV_LATENCY-1]),
        .out_valid (buf_out_valid),
        .out_ready (out_ready),
        .out_data  (buf_out)
    );

    assign pop = ce && buf_out_valid && out_ready;

    // each word launched on alternate edges of the output clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_clk  <= 1'b0;
            out_data <= '0;
        end else if (pop) begin
            out_clk  <= !out_clk;
            out_data <= buf_out;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [3:0] run_r;  // consecutive advancing edges, saturating

    // count unbroken pipeline advances
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r <= 4'h0;
        end else if (!adv) begin
            run_r <= 4'h0;
        end else if (run_r != 4'ha) begin
            run_r <= run_r + 4'h1;
        end
    end

    swing_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && req && we_i && sel_i[0] && hit[5] && dat_i[1:0] != 2'h3)
        |=> !cfg.swing_on)
        else $error("swing enabled by a reserved or off code");

    low_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.low_clock_ok |-> (regs_r[0][0] && regs_r[1][0]
                              && regs_r[2][0] && regs_r[3][0]))
        else $error("low clock mode without all check bits");

    pin_rule_a: assert property (@(posedge clk) disable iff (!rst_n)
        !override_bit |-> cfg.enh_on == enhancement_select_pin)
        else $error("enhancement not following its pin");

    dis_effect_a: assert property (@(posedge clk) disable iff (!rst_n)
        (override_bit && dis_bit) |-> !cfg.enh_on)
        else $error("enhancement on while disabled");

    reset_zero_a: assert property (@(posedge clk)
        $past(!rst_n) |-> (cfg.pdn == 4'h0 && !cfg.swing_on
                           && !cfg.low_clock_ok && dat_o == '0))
        else $error("register not zero after reset");

    pdn_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (adv && cfg.pdn[2]) |=> pipe_r[0].c == 14'h0000)
        else $error("powered down channel gave data");

    same_instant_a: assert property (@(negedge clk) disable iff (!rst_n)
        ce |=> cap_r == $past(conv_code))
        else $error("channels not sampled together");

    latency_ten_a: assert property (@(posedge clk) disable iff (!rst_n)
        (run_r == 4'ha && cfg.pdn == 4'h0 && $past(cfg.pdn, 10) == 4'h0)
        |-> pipe_r[9].a == to_tc($past(cap_r.a, 10), 1'b0))
        else $error("result not ten clocks after sampling");

    twos_comp_a: assert property (@(posedge clk) disable iff (!rst_n)
        (adv && !cfg.pdn[1]) |=> pipe_r[0].b[13] != $past(cap_r.b[13]))
        else $error("sign bit not inverted");

    ddr_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
        pop |=> (out_clk != $past(out_clk) && out_data == $past(buf_out)))
        else $error("word not launched on an output edge");

    stall_cov: cover property (@(posedge clk) disable iff (!rst_n)
        buf_out_valid && !out_ready ##1 !buf_in_ready);
    override_cov: cover property (@(posedge clk) disable iff (!rst_n)
        override_bit && dis_bit && enhancement_select_pin);
    low_clock_cov: cover property (@(posedge clk) disable iff (!rst_n)
        cfg.low_clock_ok);
endmodule

/* dv/rx_model.sv */
`timescale 1ns/100ps
// data capture receiver, takes one word on every out_clk change
module rx_model (
    // clocking
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // stall request from the bench
    input  wire logic                       stall,
    // converter output port
    input  wire logic                       out_clk,
    input  wire adc_misc_pkg::quad_sample_t out_data,
    output logic                            out_ready,
    // capture log
    output int                              words
);
    logic prev_clk_r; // out_clk at the previous edge

    // ready is registered, so a stall lands one cycle late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= !stall;
        end
    end

    // both out_clk directions carry a word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_clk_r <= 1'b0;
            words      <= 0;
        end else begin
            prev_clk_r <= out_clk;
            if (out_clk != prev_clk_r) begin
                words <= words + 1;
            end
        end
    end
endmodule

/* dv/adc_misc_config_regs_tb.sv */
`timescale 1ns/100ps
`include "adc_misc_regs.svh"
// bench for the configuration registers and output path
module adc_misc_config_regs_tb;
    logic clk, rst_n, ce, pin, stall;          // clocking and pins
    logic cyc_i, stb_i, we_i;                  // bus request
    logic [9:0] adr_i;                         // byte address
    logic [3:0] sel_i;                         // byte lanes
    logic [31:0] dat_i, dat_o;                 // bus data
    logic ack_o, out_ready, out_clk;           // handshakes
    adc_misc_pkg::quad_sample_t conv_code;     // raw codes in
    adc_misc_pkg::quad_sample_t out_data;      // words out
    adc_misc_pkg::conv_cfg_t    cfg;           // decoded config
    int mismatches, checked, cycles, words;    // bookkeeping
    logic [7:0] rd;                            // read result

    adc_misc_config_regs dut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .enhancement_select_pin(pin), .conv_code(conv_code), .cfg(cfg),
        .out_ready(out_ready), .out_clk(out_clk), .out_data(out_data));
    rx_model rx (.clk(clk), .rst_n(rst_n), .stall(stall),
        .out_clk(out_clk), .out_data(out_data), .out_ready(out_ready),
        .words(words));

    // 100 MHz clock
    always #5 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    // verdict
    task automatic summarize();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // single comparison
    task automatic chk(input logic [63:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s %h/%h", $time, what, got, exp);
        end
    endtask

    // one classic cycle, waits for ack
    task automatic xfer(input logic w, input logic [7:0] idx, wd);
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'h0};
        dat_i <= {24'h0, wd};
        // wait ends on ack, the hang guard ends a wait that never sees one
        do begin
            @(posedge clk);
        end while (ack_o !== 1'b1);
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    // read and compare
    task automatic rchk(input logic [7:0] idx, exp);
        xfer(1'b0, idx, 8'h00);
        chk(rd, exp, "read");
    endtask

    // expected output word
    function automatic adc_misc_pkg::quad_sample_t tc(
        input adc_misc_pkg::quad_sample_t q);
        tc = q;
        tc.a[13] = ~q.a[13];
        tc.b[13] = ~q.b[13];
        tc.c[13] = ~q.c[13];
        tc.d[13] = ~q.d[13];
    endfunction

    logic [7:0] idx_t [9] = '{`IDX_LCC_A, `IDX_LCC_B, `IDX_LCC_C,
        `IDX_LCC_D, `IDX_OVERRIDE, `IDX_SWING, `IDX_TUNING_B, `IDX_PDN,
        `IDX_ENH_DIS};
    logic [7:0] msk_t [9] = '{`MSK_LCC, `MSK_LCC, `MSK_LCC, `MSK_LCC,
        `MSK_OVERRIDE, `MSK_SWING, `MSK_TUNING_B, `MSK_PDN, `MSK_ENH_DIS};

    // reset values, masks and an unmapped slot
    task automatic t_regs();
        for (int i = 0; i < 9; i++) rchk(idx_t[i], 8'h00);
        chk(cfg, {3'h0, pin, 4'h0}, "cfg reset");
        for (int i = 0; i < 9; i++) xfer(1'b1, idx_t[i], msk_t[i]);
        xfer(1'b1, 8'h00, 8'hff);
        for (int i = 0; i < 9; i++) rchk(idx_t[i], msk_t[i]);
        rchk(8'h00, 8'h00);
        for (int i = 0; i < 9; i++) xfer(1'b1, idx_t[i], 8'h00);
    endtask

    // swing codes, check bits, enhancement control
    task automatic t_cfg();
        // reserved swing codes are never written
        for (int c = 0; c < 4; c += 3) begin
            xfer(1'b1, `IDX_SWING, c[7:0]);
            chk(cfg.swing_on, c == 3, "swing");
        end
        xfer(1'b1, `IDX_LCC_A, 8'h01);
        xfer(1'b1, `IDX_LCC_B, 8'h01);
        xfer(1'b1, `IDX_LCC_C, 8'h01);
        chk(cfg.low_clock_ok, 1'b0, "three bits");
        xfer(1'b1, `IDX_LCC_D, 8'h01);
        chk(cfg.low_clock_ok, 1'b1, "four bits");
        xfer(1'b1, `IDX_LCC_B, 8'h00);
        chk(cfg.low_clock_ok, 1'b0, "one cleared");
        xfer(1'b1, `IDX_ENH_DIS, 8'h01);
        for (int p = 0; p < 2; p++) begin
            pin <= p[0];
            xfer(1'b1, `IDX_OVERRIDE, 8'h00);
            chk(cfg.enh_on, p[0], "pin rules");
            xfer(1'b1, `IDX_OVERRIDE, 8'h80);
            chk(cfg.enh_on, 1'b0, "disabled");
            xfer(1'b1, `IDX_ENH_DIS, 8'h00);
            chk(cfg.enh_on, 1'b1, "enabled");
            xfer(1'b1, `IDX_ENH_DIS, 8'h01);
        end
        xfer(1'b1, `IDX_OVERRIDE, 8'h00);
        // check bits off once functional checking is over
        xfer(1'b1, `IDX_LCC_A, 8'h00);
        xfer(1'b1, `IDX_LCC_C, 8'h00);
        xfer(1'b1, `IDX_LCC_D, 8'h00);
        chk(cfg.low_clock_ok, 1'b0, "check bits off");
        // recommended tuning values for the band in use
        xfer(1'b1, `IDX_SWING, 8'h20);
        rchk(`IDX_SWING, 8'h20);
        chk(cfg.swing_on, 1'b0, "tuning only");
        xfer(1'b1, `IDX_TUNING_B, 8'h42);
        rchk(`IDX_TUNING_B, 8'h42);
    endtask

    // simultaneous capture, latency and coding
    task automatic t_data();
        adc_misc_pkg::quad_sample_t q0, q1, e;
        int k;
        q0 = {14'h1234, 14'h2000, 14'h0000, 14'h3fff};
        q1 = {14'h0abc, 14'h3001, 14'h1fff, 14'h2000};
        @(posedge clk);
        conv_code <= q0;
        repeat (20) @(posedge clk);
        chk(out_data, tc(q0), "coding");
        conv_code <= q1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
            @(negedge clk);
        end while (out_data === tc(q0) && k < 30);
        chk(out_data, tc(q1), "same instant");
        chk(k == 11 || k == 12, 1'b1, "latency");
        xfer(1'b1, `IDX_PDN, 8'h05);
        chk(cfg.pdn, 4'h5, "pdn cfg");
        repeat (15) @(posedge clk);
        e = tc(q1);
        e.a = '0;
        e.c = '0;
        chk(out_data, e, "pdn word");
        xfer(1'b1, `IDX_PDN, 8'h00);
    endtask

    // receiver stall then back to back delivery
    task automatic t_stall();
        int w0;
        logic c0;
        @(posedge clk);
        stall <= 1'b1;
        repeat (3) @(posedge clk);
        w0 = words;
        c0 = out_clk;
        repeat (20) @(posedge clk);
        chk(words - w0, 0, "stalled");
        chk(out_clk, c0, "clk still");
        stall <= 1'b0;
        repeat (4) @(posedge clk);
        w0 = words;
        repeat (10) @(posedge clk);
        chk(words - w0, 10, "ddr words");
        chk(out_data, {14'h2abc, 14'h1001, 14'h3fff, 14'h0000}, "word");
    endtask

    // clock enable low freezes the output port
    task automatic t_freeze();
        int w0;
        logic c0;
        @(posedge clk);
        ce <= 1'b0;
        // let the last launched word reach the receiver count
        repeat (2) @(posedge clk);
        w0 = words;
        c0 = out_clk;
        repeat (8) @(posedge clk);
        chk(out_clk, c0, "ce frozen clk");
        chk(words - w0, 0, "ce frozen words");
        ce <= 1'b1;
    endtask

    // reset, then scenarios
    initial begin
        {clk, ce, pin, stall, cyc_i, stb_i, we_i} = 7'h20;
        {adr_i, sel_i, dat_i, conv_code} = '0;
        sel_i = 4'h1;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_cfg();
        t_data();
        t_stall();
        t_freeze();
        summarize();
    end
endmodule
